// *** logic/usi_regs.sv ***
/*
 * Shortcut register, interrupt enable register and sticky event status
 * of an asynchronous serial port, with one level interrupt output.
 * Assumes events arrive as one-cycle pulses from logic on REF_CLK and
 * that the register master obeys the plain strobe protocol.
 */
// Local design decision: the address-and-strobe port.
`include "usi_defs.svh"
`default_nettype none

module usi_regs (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic [11:0] ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        EV_CTS,
    input  wire logic        EV_CLEAR_TO_SEND_DEASSERTED,
    input  wire logic        EV_RX_BYTE_READY,
    input  wire logic        EV_RX_BUFFER_END,
    input  wire logic        EV_TX_BYTE_SENT,
    input  wire logic        EV_TX_BUFFER_END,
    input  wire logic        EV_ERROR,
    input  wire logic        EV_RECEIVER_TIMEOUT,
    input  wire logic        EV_RECEIVER_STARTED,
    input  wire logic        EV_TRANSMITTER_STARTED,
    input  wire logic        EV_TRANSMITTER_STOPPED,
    output logic             RECEIVE_START_TASK,
    output logic             RECEIVE_STOP_TASK,
    output logic             IRQ
);

    usi_pkg::usi_bus_req_t bus;
    usi_pkg::usi_tasks_t   tasks_d;
    usi_pkg::usi_tasks_t   tasks_q;
    logic [31:0]           shortcut_q;
    logic [31:0]           shortcut_d;
    logic [31:0]           enable_q;
    logic [31:0]           enable_d;
    logic [31:0]           status_q;
    logic [31:0]           status_d;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic [31:0]           ev_vec;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // Gather event pulses into the enable layout
    always_comb
    begin
        ev_vec = 32'h0000_0000;
        ev_vec[`USI_EV_CTS]     = EV_CTS;
        ev_vec[`USI_EV_CTS_OFF] = EV_CLEAR_TO_SEND_DEASSERTED;
        ev_vec[`USI_EV_RXRDY]   = EV_RX_BYTE_READY;
        ev_vec[`USI_EV_RXEND]   = EV_RX_BUFFER_END;
        ev_vec[`USI_EV_TXSENT]  = EV_TX_BYTE_SENT;
        ev_vec[`USI_EV_TXEND]   = EV_TX_BUFFER_END;
        ev_vec[`USI_EV_ERROR]   = EV_ERROR;
        ev_vec[`USI_EV_RX_TIMEOUT] = EV_RECEIVER_TIMEOUT;
        ev_vec[`USI_EV_RXSTART] = EV_RECEIVER_STARTED;
        ev_vec[`USI_EV_TXSTART] = EV_TRANSMITTER_STARTED;
        ev_vec[`USI_EV_TXSTOP]  = EV_TRANSMITTER_STOPPED;
    end

    always_comb
    begin
        shortcut_d = shortcut_q;
        enable_d = enable_q;
        status_d = status_q;
        rdata_d  = 32'h0000_0000;
        if (bus.wr && hit(bus.addr, `USI_OFF_SHORTCUT))
        begin
            shortcut_d = bus.wdata & `USI_SHORTCUT_MASK;
        end
        if (bus.wr && hit(bus.addr, `USI_OFF_ENABLE))
        begin
            enable_d = bus.wdata & `USI_EVENT_MASK;
        end
        if (bus.wr && hit(bus.addr, `USI_OFF_STATUS))
        begin
            status_d = status_q & ~bus.wdata;
        end
        // Set after clear so an event in the clearing cycle is kept
        status_d = status_d | (ev_vec & `USI_EVENT_MASK);
        if (bus.rd)
        begin
            case (bus.addr)
                `USI_OFF_SHORTCUT: rdata_d = shortcut_q;
                `USI_OFF_ENABLE: rdata_d = enable_q;
                `USI_OFF_STATUS: rdata_d = status_q;
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Shortcut tasks fire one cycle after the buffer-end pulse
    always_comb
    begin
        tasks_d.start_rx = EV_RX_BUFFER_END && shortcut_q[`USI_SC_RESTART_BIT];
        tasks_d.stop_rx  = EV_RX_BUFFER_END && shortcut_q[`USI_SC_HALT_BIT];
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            shortcut_q <= `USI_SHORTCUT_RESET;
            enable_q <= `USI_ENABLE_RESET;
            status_q <= `USI_STATUS_RESET;
            rdata_q  <= 32'h0000_0000;
            tasks_q  <= '0;
        end
        else
        begin
            shortcut_q <= shortcut_d;
            enable_q <= enable_d;
            status_q <= status_d;
            rdata_q  <= rdata_d;
            tasks_q  <= tasks_d;
        end
    end

    assign RDATA              = rdata_q;
    assign RECEIVE_START_TASK = tasks_q.start_rx;
    assign RECEIVE_STOP_TASK  = tasks_q.stop_rx;
    // Each flag gated by its own enable bit
    assign IRQ = |(status_q & enable_q);

endmodule

`default_nettype wire

// *** logic/usi_defs.svh ***
/*
 * Register offsets, field positions and reset values of the serial port
 * shortcut and interrupt-enable slice.
 * Assumes a 32-bit plain register port with byte addresses.
 */
`ifndef USI_DEFS_SVH
`define USI_DEFS_SVH

`define USI_ADDR_W          12
`define USI_OFF_SHORTCUT    12'h200
`define USI_OFF_ENABLE      12'h300
`define USI_OFF_STATUS      12'h310
`define USI_SHORTCUT_RESET  32'h0000_0000
`define USI_ENABLE_RESET    32'h0000_0000
`define USI_STATUS_RESET    32'h0000_0000
`define USI_SC_RESTART_BIT  5
`define USI_SC_HALT_BIT     6
`define USI_SHORTCUT_MASK   32'h0000_0060
`define USI_EVENT_MASK      32'h005a_0397
`define USI_EV_CTS          0
`define USI_EV_CTS_OFF      1
`define USI_EV_RXRDY        2
`define USI_EV_RXEND        4
`define USI_EV_TXSENT       7
`define USI_EV_TXEND        8
`define USI_EV_ERROR        9
`define USI_EV_RX_TIMEOUT   17
`define USI_EV_RXSTART      19
`define USI_EV_TXSTART      20
`define USI_EV_TXSTOP       22

`endif

// *** logic/usi_pkg.sv ***
/*
 * Types shared by the shortcut and interrupt-enable slice.
 * Assumes nothing beyond the constants header.
 */
`default_nettype none
package usi_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } usi_bus_req_t;

    typedef struct packed {
        logic start_rx;
        logic stop_rx;
    } usi_tasks_t;
endpackage
`default_nettype wire

// *** verif/usi_chk.sv ***
/* Port checker for usi_regs: register port, shortcut and interrupt relations.
   Bound into usi_regs from the bench; uses the constants header. */
`include "usi_defs.svh"
`default_nettype none
module usi_chk (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        EV_RX_BYTE_READY,
    input wire logic        EV_RX_BUFFER_END,
    input wire logic        RECEIVE_START_TASK,
    input wire logic        RECEIVE_STOP_TASK,
    input wire logic        IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_wr(a); WR && ADDR == a; endsequence
    sequence s_rd(a); RD && ADDR == a; endsequence
    a_start_cause: assert property (RECEIVE_START_TASK |-> $past(EV_RX_BUFFER_END))
        else $error("start task without buffer end");
    a_stop_cause: assert property (RECEIVE_STOP_TASK |-> $past(EV_RX_BUFFER_END))
        else $error("stop task without buffer end");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside its slot");
    a_event_task_shortcuts_back: assert property (s_wr(12'h200) ##1 s_rd(12'h200) |=>
        RDATA == ($past(WDATA, 2) & `USI_SHORTCUT_MASK)) else $error("shortcut readback");
    a_enable_back: assert property (s_wr(12'h300) ##1 s_rd(12'h300) |=>
        RDATA == ($past(WDATA, 2) & `USI_EVENT_MASK)) else $error("enable readback");
    a_mask_drop: assert property (s_wr(12'h300) ##0 WDATA == 32'h0 |=> !IRQ)
        else $error("irq with all enables off");
    a_ready_irq: assert property (s_wr(12'h300) ##0 WDATA[2] ##1 EV_RX_BYTE_READY |=> IRQ)
        else $error("enabled byte ready gave no irq");
    a_end_irq: assert property (s_wr(12'h300) ##0 WDATA[4] ##1 EV_RX_BUFFER_END |=> IRQ)
        else $error("enabled buffer end gave no irq");
endmodule
`default_nettype wire

// *** verif/usi_regs_bench.sv ***
/* Self-checking bench for usi_regs: register port, event pulses and IRQ.
   Every stimulus cycle after reset release passes through drv; needs usi_chk. */
`default_nettype none
module usi_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        REF_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [11:0] ADDR = 12'h0;
    logic [31:0] WDATA = 32'h0;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [10:0] ev = 11'h0;
    logic [31:0] RDATA;
    logic        RECEIVE_START_TASK;
    logic        RECEIVE_STOP_TASK;
    logic        IRQ;
    logic [31:0] m;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          pos[11] = '{0, 1, 2, 4, 7, 8, 9, 17, 19, 20, 22};
    usi_regs i_dut (.*, .EV_CTS(ev[0]), .EV_CLEAR_TO_SEND_DEASSERTED(ev[1]),
        .EV_RX_BYTE_READY(ev[2]), .EV_RX_BUFFER_END(ev[3]), .EV_TX_BYTE_SENT(ev[4]),
        .EV_TX_BUFFER_END(ev[5]), .EV_ERROR(ev[6]), .EV_RECEIVER_TIMEOUT(ev[7]),
        .EV_RECEIVER_STARTED(ev[8]), .EV_TRANSMITTER_STARTED(ev[9]),
        .EV_TRANSMITTER_STOPPED(ev[10]));
    always #20 REF_CLK = ~REF_CLK;
    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One call is one clock cycle of inputs; levels hold until the next call
    task automatic drv(input logic w, input logic r, input logic [11:0] a,
                       input logic [31:0] d, input logic [10:0] e);
        WR <= w;
        RD <= r;
        ADDR <= a;
        WDATA <= d;
        ev <= e;
        @(posedge REF_CLK);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        drv(1'b0, 1'b1, a, 32'h0, 11'h0);
        #1 cmp(RDATA, exp);
    endtask
    task automatic ck(input logic exp);
        drv(1'b0, 1'b0, 12'h0, 32'h0, 11'h0);
        #1 cmp({31'h0, IRQ}, {31'h0, exp});
    endtask
    always @(posedge REF_CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            failures++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge REF_CLK);
        RST <= 1'b0;
        rdc(12'h200, 32'h0);
        rdc(12'h300, 32'h0);
        rdc(12'h104, 32'h0);
        drv(1'b1, 1'b0, 12'h300, 32'hffff_ffff, 11'h0);
        rdc(12'h300, 32'h005a_0397);
        drv(1'b1, 1'b0, 12'h200, 32'hffff_ffff, 11'h0);
        rdc(12'h200, 32'h0000_0060);
        for (int s = 0; s < 4; s++)
        begin
            drv(1'b1, 1'b0, 12'h200, 32'(s) << 5, 11'h0);
            drv(1'b0, 1'b0, 12'h0, 32'h0, 11'h008);
            #1 cmp({30'h0, RECEIVE_STOP_TASK, RECEIVE_START_TASK}, 32'(s));
        end
        drv(1'b1, 1'b0, 12'h310, 32'hffff_ffff, 11'h0);
        for (int i = 0; i < 11; i++)
        begin
            m = 32'h1 << pos[i];
            drv(1'b1, 1'b0, 12'h300, m, 11'h0);
            drv(1'b0, 1'b0, 12'h0, 32'h0, 11'h1 << i);
            ck(1'b1);
            drv(1'b1, 1'b0, 12'h300, 32'h0, 11'h0);
            ck(1'b0);
            drv(1'b1, 1'b0, 12'h310, m, 11'h0);
            drv(1'b0, 1'b0, 12'h0, 32'h0, 11'h1 << i);
            ck(1'b0);
            rdc(12'h310, m);
            drv(1'b1, 1'b0, 12'h300, m, 11'h0);
            ck(1'b1);
            drv(1'b1, 1'b0, 12'h310, m, 11'h0);
            ck(1'b0);
        end
        end_of_test();
    end
endmodule
bind usi_regs usi_chk i_chk (.*);
`default_nettype wire
